/* adl_pkg.sv */
/*
  Package for the long-format diagnostic message framer: frame geometry,
  control register layout, service codes, cause and state encodings and the
  structs that carry the message snapshot and the stored configuration.
  Assumes a single 40 MHz clock domain; used by adl_framer and its bench.
*/
`default_nettype none
package adl_pkg;
  // Frame geometry in bytes
  localparam int unsigned LONG_LEN      = 62;
  localparam int unsigned SHORT_LEN     = 16;
  localparam int unsigned STD_HDR_LEN   = 6;
  localparam int unsigned OFF_EXT_HDR   = 6;
  localparam int unsigned OFF_RESERVED  = 56;
  localparam int unsigned RESERVED_LEN  = 6;
  localparam logic [7:0]  LONG_HDR_VAL  = 8'(LONG_LEN - STD_HDR_LEN);
  localparam logic [7:0]  SHORT_HDR_VAL = 8'(SHORT_LEN - STD_HDR_LEN);
  localparam logic [5:0]  LONG_LAST     = 6'(LONG_LEN - 1);
  localparam logic [5:0]  SHORT_LAST    = 6'(SHORT_LEN - 1);

  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT  = 8'h08;

  // Control register fields
  localparam int unsigned CTRL_EXT   = 0;
  localparam int unsigned CTRL_COMM  = 2;
  localparam int unsigned CTRL_SCALE = 3;
  localparam int unsigned CTRL_SPEC  = 6;
  localparam int unsigned CTRL_PROG  = 7;
  localparam int unsigned CTRL_ENC   = 8;
  localparam logic [15:0] CTRL_RESET = 16'h0F00;
  localparam logic [15:0] CTRL_WMASK = 16'hFFCD;

  // Encoder type codes
  localparam logic [7:0] ENC_SINGLETURN = 8'h00;
  localparam logic [7:0] ENC_MULTITURN  = 8'h01;
  localparam logic [7:0] ENC_LINEAR     = 8'h07;
  localparam logic [7:0] ENC_CASSETTE   = 8'h0F;

  // Special service codes and axis field values
  localparam logic [7:0] ERROR_POLL_COMMAND  = 8'h41;
  localparam logic [7:0] PRESET_SELECT_CMD_A = 8'h40;
  localparam logic [7:0] PRESET_SELECT_CMD_B = 8'h60;
  localparam logic [7:0] AXIS_PRESET_FLAG    = 8'h80;
  localparam logic [7:0] AXIS_CASSETTE       = 8'h00;
  localparam logic [7:0] ALARM_KEEP_MASK     = 8'hE0;
  localparam logic [7:0] ALARM_POLL_MASK     = 8'h0F;
  localparam logic [7:0] ALARM_VALID_MASK    = 8'hEF;

  // Message causes, one-hot; lower bit has priority
  typedef enum logic [5:0] {
    CAUSE_NONE   = 6'b000000,
    CAUSE_ERROR  = 6'b000001,
    CAUSE_PRESET = 6'b000010,
    CAUSE_POLL   = 6'b000100,
    CAUSE_SVC    = 6'b001000,
    CAUSE_PROG   = 6'b010000,
    CAUSE_SELECT = 6'b100000
  } adl_cause_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } adl_state_e;

  typedef logic [3:0][15:0] adl_err_t;

  // Per-message variable part
  typedef struct packed {
    logic [7:0] alarms;
    logic [7:0] axis;
    logic [7:0] axis_map;
    adl_err_t   err;
  } adl_msg_s;

  // Stored configuration, loaded at message start
  typedef struct packed {
    logic [15:0] profile_ver;
    logic [15:0] software_ver;
    logic [31:0] op_time;
    logic [31:0] steps_per_rev;
    logic [15:0] revolutions;
    logic [31:0] meas_length;
    logic [15:0] meas_num;
    logic [15:0] meas_den;
    logic [31:0] value_offset;
    logic [31:0] mfr_offset;
    logic [31:0] article_no;
    logic [15:0] serial_no;
  } adl_cfg_s;
endpackage
`default_nettype wire

/* adl_framer.sv */
/*
  Long/short diagnostic message framer of a multi-axis encoder cassette.
  Collects message causes, snapshots the variable fields and streams the
  frame byte by byte, most significant byte first.
  Assumes all event and status inputs come from logic on mclk_in and that
  the stream consumer raises msg_ready_in when it takes a byte.
*/
// The implementer's own choices: the register offsets and the plain strobed port.
// Summary of operation
// - Long message 62 bytes, 56 user bytes
// - Long format only in extended mode
// - Byte 6 gives count of diagnostic bytes
// - Byte 7 holds alarm flags
// - Byte 8 holds operating status bits
// - Byte 9 holds encoder type code
// - Byte 10 names cassette or axis
// - Byte 11 maps axes still in error
// - Four error numbers, newest first
// - Nameplate steps and revolutions at 28, 32
// - Scaled measured-value offset at 42
// - Unscaled manufacturer offset at 46
// - Six reserved bytes at 56 are zero
// - New error: axis, errors zero; map set
// - Preset: axis MSB set, preset axes map
// - Message after every special service
// - Error poll returns axis, map, errors
// - Error poll refreshes alarm bits 0-3
// - Programming: axis and value echoed
// - Preset preselection change: bare message
// - Poll acknowledges; then alarms cleared
`timescale 1ns/1ps
`default_nettype none
module adl_framer (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             sys_rst_in,
  // Register port
  input  wire logic [7:0]       reg_addr_in,
  input  wire logic [31:0]      reg_wdata_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  output logic      [31:0]      reg_rdata_out,
  // Events
  input  wire logic             new_error_in,
  input  wire logic             preset_done_in,
  input  wire logic [7:0]       preset_axes_in,
  input  wire logic             svc_done_in,
  input  wire logic [7:0]       svc_code_in,
  input  wire logic [3:0]       svc_axis_in,
  input  wire logic             prog_done_in,
  input  wire logic [3:0]       prog_axis_in,
  input  wire logic [31:0]      prog_value_in,
  // Live status
  input  wire logic [7:0]       alarm_set_in,
  input  wire logic [7:0]       alarm_live_in,
  input  wire logic [7:0]       err_axes_in,
  input  wire adl_pkg::adl_err_t err_num_in,
  input  wire logic [47:0]      std_hdr_in,
  input  wire adl_pkg::adl_cfg_s cfg_in,
  // Message stream
  output logic                  msg_valid_out,
  output logic      [7:0]       msg_byte_out,
  output logic                  msg_first_out,
  output logic                  msg_last_out,
  input  wire logic             msg_ready_in,
  // Error handshake and flags
  output logic                  err_ack_out,
  output logic                  error_summary_flag_out,
  output logic                  pos_error_out
);

  adl_pkg::adl_state_e state_q;
  logic [5:0]          pend_q;
  logic [5:0]          cause_q;
  logic [7:0]          preset_map_q;
  logic [7:0]          poll_axis_q;
  logic [7:0]          prog_axis_q;
  logic [31:0]         prog_val_q;
  logic [7:0]          alarm_q;
  logic                errors_open_q;
  logic [15:0]         ctrl_q;
  logic [15:0]         msg_count_q;
  adl_pkg::adl_msg_s   snap_q;
  adl_pkg::adl_cfg_s   cfg_q;
  logic [47:0]         hdr_q;
  logic                long_q;
  logic [7:0]          op_q;
  logic [7:0]          enc_q;
  logic [5:0]          idx_q;
  logic [5:0]          cur_idx_q;
  logic [5:0]          sent_cnt_q;

  // Event decode
  wire is_poll   = svc_done_in && (svc_code_in == adl_pkg::ERROR_POLL_COMMAND);
  wire is_select = svc_done_in && ((svc_code_in == adl_pkg::PRESET_SELECT_CMD_A) ||
                                   (svc_code_in == adl_pkg::PRESET_SELECT_CMD_B));
  wire is_svc    = svc_done_in && !is_poll && !is_select;
  wire [5:0] new_pend = {is_select, prog_done_in, is_svc, is_poll,
                         preset_done_in, new_error_in};

  // Lowest pending cause wins
  wire [5:0] grant    = pend_q & 6'(~pend_q + 6'h01);
  wire       start    = (state_q == adl_pkg::ST_IDLE) && (pend_q != 6'h00);
  wire       take     = msg_valid_out && msg_ready_in;
  wire       can_load = (state_q == adl_pkg::ST_SEND) && (!msg_valid_out || msg_ready_in);
  wire [5:0] last_idx = long_q ? adl_pkg::LONG_LAST : adl_pkg::SHORT_LAST;
  wire       final_take = take && msg_last_out;
  wire       poll_start = start && (grant == adl_pkg::CAUSE_POLL);

  // Register decode
  wire sel_ctrl   = reg_addr_in == adl_pkg::ADDR_CTRL;
  wire sel_status = reg_addr_in == adl_pkg::ADDR_STATUS;
  wire sel_count  = reg_addr_in == adl_pkg::ADDR_COUNT;
  wire [31:0] status_word = {8'h00, pend_q, errors_open_q, (state_q == adl_pkg::ST_SEND),
                             alarm_q, err_axes_in};
  wire [31:0] next_rdata  = sel_ctrl   ? {16'h0000, ctrl_q} :
                            sel_status ? status_word :
                            sel_count  ? {16'h0000, msg_count_q} : 32'h0000_0000;

  wire [7:0] op_status = {ctrl_q[adl_pkg::CTRL_PROG], ctrl_q[adl_pkg::CTRL_SPEC], 2'b00,
                          ctrl_q[adl_pkg::CTRL_SCALE], ctrl_q[adl_pkg::CTRL_COMM],
                          ctrl_q[adl_pkg::CTRL_EXT], 1'b0};

  wire [7:0] alarm_byte = (alarm_q & adl_pkg::ALARM_KEEP_MASK) |
                          (poll_start ? (alarm_live_in & adl_pkg::ALARM_POLL_MASK)
                                      : (alarm_q & adl_pkg::ALARM_POLL_MASK));

  // Snapshot of the variable fields for the granted cause
  adl_pkg::adl_msg_s next_snap;
  always_comb begin
    next_snap        = '0;
    next_snap.alarms = alarm_byte;
    case (grant)
      adl_pkg::CAUSE_ERROR: begin
        next_snap.axis     = adl_pkg::AXIS_CASSETTE;
        next_snap.axis_map = err_axes_in;
      end
      adl_pkg::CAUSE_PRESET: begin
        next_snap.axis     = adl_pkg::AXIS_PRESET_FLAG;
        next_snap.axis_map = preset_map_q;
      end
      adl_pkg::CAUSE_POLL: begin
        next_snap.axis     = poll_axis_q;
        next_snap.axis_map = err_axes_in;
        next_snap.err      = err_num_in;
      end
      adl_pkg::CAUSE_SVC: begin
        next_snap.axis     = adl_pkg::AXIS_CASSETTE;
        next_snap.axis_map = err_axes_in;
      end
      adl_pkg::CAUSE_PROG: begin
        next_snap.axis     = prog_axis_q;
        next_snap.err[3]   = prog_val_q[31:16];
        next_snap.err[2]   = prog_val_q[15:0];
      end
      adl_pkg::CAUSE_SELECT: begin
        next_snap.axis     = adl_pkg::AXIS_CASSETTE;
      end
      default: begin
        next_snap.axis     = adl_pkg::AXIS_CASSETTE;
      end
    endcase
  end

  // full frame, MSB first, field order
  // header byte counts itself and following bytes, reserved zero
  wire [8*adl_pkg::LONG_LEN-1:0] frame_w = {
    hdr_q,
    (long_q ? adl_pkg::LONG_HDR_VAL : adl_pkg::SHORT_HDR_VAL),
    snap_q.alarms & adl_pkg::ALARM_VALID_MASK, op_q, enc_q,
    snap_q.axis, snap_q.axis_map, snap_q.err,
    cfg_q.profile_ver, cfg_q.software_ver, cfg_q.op_time,
    cfg_q.steps_per_rev, cfg_q.revolutions,
    cfg_q.meas_length, cfg_q.meas_num, cfg_q.meas_den,
    cfg_q.value_offset, cfg_q.mfr_offset,
    cfg_q.article_no, cfg_q.serial_no,
    {(8*adl_pkg::RESERVED_LEN){1'b0}}};
  wire [7:0] sel_byte = frame_w[8*(adl_pkg::LONG_LEN - 1 - 32'(idx_q)) +: 8];

  // Register port
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ctrl_q        <= adl_pkg::CTRL_RESET;
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      if (reg_wr_in && sel_ctrl) begin
        ctrl_q <= reg_wdata_in[15:0] & adl_pkg::CTRL_WMASK;
      end
      reg_rdata_out <= reg_rd_in ? next_rdata : 32'h0000_0000;
    end
  end

  // Cause collection; a new event beats the clear of its own bit
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pend_q       <= 6'h00;
      preset_map_q <= 8'h00;
      poll_axis_q  <= 8'h00;
      prog_axis_q  <= 8'h00;
      prog_val_q   <= 32'h0000_0000;
    end else begin
      // every special service queues a message
      pend_q <= (start ? (pend_q & ~grant) : pend_q) | new_pend;
      if (preset_done_in) begin
        preset_map_q <= ((start && grant == adl_pkg::CAUSE_PRESET) ? 8'h00 : preset_map_q)
                        | preset_axes_in;
      end else if (start && grant == adl_pkg::CAUSE_PRESET) begin
        preset_map_q <= 8'h00;
      end
      if (is_poll) begin
        poll_axis_q <= {4'h0, svc_axis_in};
      end
      if (prog_done_in) begin
        prog_axis_q <= {4'h0, prog_axis_in};
        prog_val_q  <= prog_value_in;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      alarm_q                <= 8'h00;
      errors_open_q          <= 1'b0;
      err_ack_out            <= 1'b0;
      error_summary_flag_out <= 1'b0;
      pos_error_out          <= 1'b0;
    end else begin
      err_ack_out            <= poll_start;
      alarm_q                <= (poll_start ? 8'h00 : alarm_q) | alarm_set_in;
      errors_open_q          <= (poll_start ? 1'b0 : errors_open_q) | new_error_in;
      error_summary_flag_out <= |alarm_q;
      pos_error_out          <= errors_open_q;
    end
  end

  // Frame sequencer
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state_q       <= adl_pkg::ST_IDLE;
      snap_q        <= '0;
      cfg_q         <= '0;
      hdr_q         <= 48'h0000_0000_0000;
      long_q        <= 1'b0;
      op_q          <= 8'h00;
      enc_q         <= 8'h00;
      idx_q         <= 6'h00;
      cur_idx_q     <= 6'h00;
      msg_valid_out <= 1'b0;
      msg_byte_out  <= 8'h00;
      msg_first_out <= 1'b0;
      msg_last_out  <= 1'b0;
      msg_count_q   <= 16'h0000;
    end else begin
      case (state_q)
        adl_pkg::ST_IDLE: begin
          if (start) begin
            snap_q  <= next_snap;
            cfg_q   <= cfg_in;
            hdr_q   <= std_hdr_in;
            long_q  <= ctrl_q[adl_pkg::CTRL_EXT];
            op_q    <= op_status;
            enc_q   <= ctrl_q[adl_pkg::CTRL_ENC +: 8];
            idx_q   <= 6'h00;
            state_q <= adl_pkg::ST_SEND;
          end
        end
        adl_pkg::ST_SEND: begin
          if (can_load && idx_q <= last_idx) begin
            msg_valid_out <= 1'b1;
            msg_byte_out  <= sel_byte;
            msg_first_out <= idx_q == 6'h00;
            msg_last_out  <= idx_q == last_idx;
            cur_idx_q     <= idx_q;
            idx_q         <= idx_q + 6'h01;
          end else if (take) begin
            msg_valid_out <= 1'b0;
            msg_first_out <= 1'b0;
            msg_last_out  <= 1'b0;
          end
          if (final_take) begin
            msg_count_q <= msg_count_q + 16'h0001;
            state_q     <= adl_pkg::ST_IDLE;
          end
        end
        default: state_q <= adl_pkg::ST_IDLE;
      endcase
    end
  end

  // Helper: bytes taken in the current frame
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      sent_cnt_q <= 6'h00;
    end else if (take) begin
      sent_cnt_q <= msg_last_out ? 6'h00 : sent_cnt_q + 6'h01;
    end
  end

  a_long_length: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    final_take && long_q |-> sent_cnt_q == adl_pkg::LONG_LAST)
    else $error("long frame length wrong");

  a_short_length: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    final_take && !long_q |-> sent_cnt_q == adl_pkg::SHORT_LAST)
    else $error("short frame length wrong");

  a_header_count: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    msg_valid_out && cur_idx_q == 6'(adl_pkg::OFF_EXT_HDR) |->
      msg_byte_out == (long_q ? 8'h38 : 8'h0A))
    else $error("extended header byte wrong");

  a_reserved_zero: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    msg_valid_out && cur_idx_q >= 6'(adl_pkg::OFF_RESERVED) |-> msg_byte_out == 8'h00)
    else $error("reserved byte not zero");

  a_error_fields: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    start && grant == adl_pkg::CAUSE_ERROR |=>
      snap_q.axis == 8'h00 && snap_q.err == '0 && snap_q.axis_map == $past(err_axes_in))
    else $error("new error fields wrong");

  a_preset_flag: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    start && grant == adl_pkg::CAUSE_PRESET |=> snap_q.axis == 8'h80)
    else $error("preset flag missing");

  a_service_queued: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    svc_done_in |=> (pend_q & 6'b101100) != 6'h00)
    else $error("special service not queued");

  a_poll_ack: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    poll_start |=> err_ack_out && (!errors_open_q || $past(new_error_in)) ##1
      (!pos_error_out || $past(new_error_in, 2)))
    else $error("poll did not acknowledge");

  a_prog_echo: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    start && grant == adl_pkg::CAUSE_PROG |=>
      {snap_q.err[3], snap_q.err[2]} == $past(prog_val_q) && snap_q.axis == $past(prog_axis_q))
    else $error("programmed value not echoed");

  a_frame_starts: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    start |=> ##[1:2] msg_valid_out && msg_first_out)
    else $error("frame did not start");

  a_poll_fields: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    poll_start |=> snap_q.axis == $past(poll_axis_q) && snap_q.axis_map == $past(err_axes_in) &&
      snap_q.err == $past(err_num_in))
    else $error("poll fields wrong");

  a_alarm_refresh: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    poll_start |=> (snap_q.alarms & 8'h0F) == ($past(alarm_live_in) & 8'h0F))
    else $error("poll alarm bits not refreshed");

  a_select_bare: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    start && grant == adl_pkg::CAUSE_SELECT |=>
      snap_q.axis == 8'h00 && snap_q.axis_map == 8'h00 && snap_q.err == '0)
    else $error("preselection message not bare");

  a_ack_single: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    err_ack_out |=> !err_ack_out)
    else $error("acknowledge longer than one cycle");

endmodule
`default_nettype wire

/* adl_master_model.sv */
/*
  Stream consumer standing in for the fieldbus master at the far side.
  Assumes the framer stream runs on mclk_in with a valid/ready handshake.
*/
`timescale 1ns/1ps
`default_nettype none
module adl_master_model (
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  // Pace select
  input  wire logic       slow_in,
  // Stream from framer
  input  wire logic       valid_in,
  input  wire logic [7:0] byte_in,
  input  wire logic       first_in,
  input  wire logic       last_in,
  output logic            ready_out,
  // Accepted byte with its marks
  output logic            take_out,
  output logic      [9:0] take_data_out
);
  logic [1:0] pace;
  assign take_out      = valid_in & ready_out;
  assign take_data_out = {first_in, last_in, byte_in};
  // Slow pace takes one byte in four
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pace      <= 2'h0;
      ready_out <= 1'b0;
    end else begin
      pace      <= pace + 2'h1;
      ready_out <= !slow_in || (pace == 2'h3);
    end
  end
endmodule
`default_nettype wire

/* axis_diag_long_format_tb.sv */
/*
  Self-checking bench for the diagnostic message framer.
  Assumes the framer of adl_pkg and the consumer model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module axis_diag_long_format_tb;
  logic mclk_in, sys_rst_in, wr, rd, rd_d, ne, pd, sd, pgd, slow, vld, fst, lst, rdy, ack, sf, pe, tk;
  logic [7:0] addr, pax, sc, aset, alive, eax, mb, sticky, ax;
  logic [3:0] sax, pax4, saxn;
  logic [31:0] wd, rdata, pv, pvn, lfsr, err_count, tests_run, ack_n, cyc;
  logic [47:0] hdr;
  logic [287:0] cv;
  logic [15:0] ctrl_v;
  logic [9:0] td;
  logic [7:0] encs [4];
  adl_pkg::adl_err_t en;
  adl_pkg::adl_cfg_s cfg;
  logic [9:0] fq [$];
  logic [31:0] rq [$];

  always #12.5 mclk_in = ~mclk_in;

  adl_framer adl_framer_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .new_error_in(ne), .preset_done_in(pd),
    .preset_axes_in(pax), .svc_done_in(sd), .svc_code_in(sc), .svc_axis_in(sax), .prog_done_in(pgd),
    .prog_axis_in(pax4), .prog_value_in(pv), .alarm_set_in(aset), .alarm_live_in(alive), .err_axes_in(eax),
    .err_num_in(en), .std_hdr_in(hdr), .cfg_in(cfg), .msg_valid_out(vld), .msg_byte_out(mb),
    .msg_first_out(fst), .msg_last_out(lst), .msg_ready_in(rdy), .err_ack_out(ack),
    .error_summary_flag_out(sf), .pos_error_out(pe));
  adl_master_model adl_master_model_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .slow_in(slow),
    .valid_in(vld), .byte_in(mb), .first_in(fst), .last_in(lst), .ready_out(rdy), .take_out(tk),
    .take_data_out(td));

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic conclude();
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask

  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    wr <= w;
    rd <= r;
    addr <= a;
    wd <= d;
    if (r) rq.push_back(e);
    @(posedge mclk_in);
  endtask

  // Whole frame noted byte by byte, most significant byte first
  task automatic push_frame(input logic [7:0] al, input logic [7:0] a, input logic [7:0] m, input adl_pkg::adl_err_t er);
    logic [495:0] f;
    int len;
    f = {hdr, ctrl_v[0] ? adl_pkg::LONG_HDR_VAL : adl_pkg::SHORT_HDR_VAL, al & adl_pkg::ALARM_VALID_MASK,
         ctrl_v[7:6], 2'b00, ctrl_v[3:2], ctrl_v[0], 1'b0, ctrl_v[15:8], a, m, er, cv, 48'h0};
    len = ctrl_v[0] ? 62 : 16;
    for (int n = 0; n < len; n++) fq.push_back({n == 0, n == len - 1, f[495 - 8 * n -: 8]});
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (fq.size() != 0 && n < 3000) begin
      @(posedge mclk_in);
      n++;
    end
    repeat (2) @(posedge mclk_in);
  endtask

  always @(posedge mclk_in) begin
    rd_d <= rd;
    cyc <= cyc + 32'h1;
    if (ack) ack_n <= ack_n + 32'h1;
    if (rd_d) check(rdata, rq.pop_front());
    if (tk) check(32'(td), fq.size() != 0 ? 32'(fq.pop_front()) : 32'hFFFFFFFF);
    if (cyc == 32'h0000_9C40) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    mclk_in = 1'b0; sys_rst_in = 1'b1; {wr, rd, rd_d, ne, pd, sd, pgd, slow} = '0;
    {addr, pax, sc, aset, alive, eax, sax, pax4, wd, pv, hdr, en, cfg} = '0;
    {err_count, tests_run, ack_n, cyc} = '0; sticky = 8'h00; lfsr = 32'h0000FEA6;
    encs = '{adl_pkg::ENC_SINGLETURN, adl_pkg::ENC_MULTITURN, adl_pkg::ENC_LINEAR, adl_pkg::ENC_CASSETTE};
    repeat (20) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    for (int k = 0; k < 9; k++) cv[k * 32 +: 32] = rnd();
    cfg <= cv; eax <= 8'(rnd()); alive <= 8'(rnd()); hdr <= {rnd(), 16'(rnd())}; en <= {rnd(), rnd()};
    bus(1'b0, 1'b1, adl_pkg::ADDR_CTRL, 32'h0, {16'h0, adl_pkg::CTRL_RESET});
    bus(1'b1, 1'b0, adl_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, 1'b0, adl_pkg::ADDR_STATUS, 32'h0, 32'h0);
    bus(1'b0, 1'b1, adl_pkg::ADDR_CTRL, 32'h0, {16'h0, adl_pkg::CTRL_WMASK});
    bus(1'b0, 1'b1, 8'h0C, 32'h0, 32'h0);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
    for (int i = 0; i < 9; i++) begin
      ctrl_v = ({encs[i % 4], 8'(rnd())} & adl_pkg::CTRL_WMASK & 16'hFFFE) | 16'(i != 7);
      bus(1'b1, 1'b0, adl_pkg::ADDR_CTRL, {16'h0, ctrl_v}, 32'h0);
      bus(1'b0, 1'b1, adl_pkg::ADDR_CTRL, 32'h0, {16'h0, ctrl_v});
      bus(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
      slow <= i[0];
      pvn = rnd();
      saxn = 4'(rnd() % 32'h9);
      pv <= pvn;
      sax <= saxn;
      sc <= i == 2 ? adl_pkg::ERROR_POLL_COMMAND : i == 5 ? adl_pkg::PRESET_SELECT_CMD_A :
            i == 6 ? adl_pkg::PRESET_SELECT_CMD_B : 8'h22;
      if (i == 0) begin
        aset <= 8'hA5; sticky = 8'hA5;
        @(posedge mclk_in);
        aset <= 8'h00;
      end
      case (i)
        0, 7: begin push_frame(sticky, 8'h00, eax, '0); ne <= 1'b1; end
        1: begin pax <= 8'h09; push_frame(sticky, adl_pkg::AXIS_PRESET_FLAG, 8'h09, '0); pd <= 1'b1; end
        2: begin
          sd <= 1'b1;
          push_frame((sticky & adl_pkg::ALARM_KEEP_MASK) | (alive & adl_pkg::ALARM_POLL_MASK), {4'h0, saxn}, eax, en);
          sticky = 8'h00;
        end
        3: begin push_frame(sticky, 8'h00, eax, '0); sd <= 1'b1; end
        4: begin pax4 <= 4'h5; push_frame(sticky, 8'h05, 8'h00, {pvn, 32'h0}); pgd <= 1'b1; end
        5, 6: begin
          sd <= 1'b1;
          push_frame(sticky, 8'h00, 8'h00, '0);
        end
        default: begin
          pax4 <= 4'h8; push_frame(sticky, 8'h00, eax, '0); push_frame(sticky, 8'h08, 8'h00, {pvn, 32'h0});
          ne <= 1'b1; pgd <= 1'b1;
        end
      endcase
      @(posedge mclk_in);
      {ne, pd, sd, pgd} <= '0;
      drain();
      if (i == 0) begin
        check(32'({sf, pe}), 32'h3);
        bus(1'b0, 1'b1, adl_pkg::ADDR_STATUS, 32'h0, {14'h0, 2'b10, sticky, eax});
        bus(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
      end
      if (i == 2) check({sf, pe, ack_n[29:0]}, 32'h1);
    end
    bus(1'b0, 1'b1, adl_pkg::ADDR_COUNT, 32'h0, 32'h0000000A);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
    @(posedge mclk_in);
    check(32'(fq.size()), 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
